//--- shared/mpba_regs.svh
`ifndef MPBA_REGS_SVH
`define MPBA_REGS_SVH
// ***********************************************************
// Constants
// ***********************************************************
`define MPBA_NUM_LINES  6
`define MPBA_ID_W       3
`define MPBA_ID_SINGLE  3'h0
`define MPBA_ID_FIRST   3'h1
`define MPBA_ID_LAST    3'h6
`define MPBA_NO_MASTER  3'h0
`define MPBA_IDX_ZERO   3'h0
`define MPBA_IDX_ONE    3'h1
`endif

//--- shared/mpba_pkg.sv
`default_nettype none
`include "mpba_regs.svh"
package mpba_pkg;
   // ********************************************************
   // Types
   // ********************************************************
   typedef logic [`MPBA_ID_W-1:0] mpba_id_t;
   typedef struct packed {
      logic o;
      logic oe;
   } mpba_pin_t;
   typedef struct packed {
      logic [`MPBA_NUM_LINES-1:0] o;
      logic [`MPBA_NUM_LINES-1:0] oe;
   } mpba_req_bus_t;
endpackage : mpba_pkg
`default_nettype wire

//--- core/mpba_prio.sv
`default_nettype none
`include "mpba_regs.svh"
module mpba_prio
   import mpba_pkg::*;
#(
   parameter int N = `MPBA_NUM_LINES
) (
   input  wire logic [N-1:0] req_in,
   input  wire mpba_id_t     start_in,
   output logic              any_out,
   output mpba_id_t          win_out
);
   // Search from start upward with wrap; first active line wins
   always_comb begin
      mpba_id_t idx;
      idx     = start_in;
      any_out = 1'b0;
      win_out = `MPBA_IDX_ZERO;
      for (int i = 0; i < N; i++) begin
         if (!any_out && req_in[idx]) begin
            any_out = 1'b1;
            win_out = idx;
         end
         idx = (idx == mpba_id_t'(N - 1)) ? `MPBA_IDX_ZERO
                                          : idx + `MPBA_IDX_ONE;
      end
   end
endmodule : mpba_prio
`default_nettype wire

//--- core/mpba_arbiter.sv
// Summary of operation
// - Ready driven low while chip select and host bus request both asserted.
// - Matching DMA grant asserted; transfer begins on the following cycle.
// - Only the bus owner drives DMA grants; others leave them undriven.
// - Drive only own request line chosen by identity; monitor all others.
// - Owner indicator high only while this device is bus master.
// - Identity 000 means single processor; owner indicator held high.
// - Identity 001 selects request line 1, up to 110 selecting line 6.
// - Priority select high gives rotating priority, low gives fixed.
`default_nettype none
`include "mpba_regs.svh"
module mpba_arbiter
   import mpba_pkg::*;
#(
   parameter int N = `MPBA_NUM_LINES
) (
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic          ce_in,
   input  wire mpba_id_t      processor_number_inputs_in,
   input  wire logic          rotating_priority_select_in,
   input  wire logic [N-1:0]  mp_bus_request_lines_n_in,
   input  wire logic          bus_want_in,
   input  wire logic          host_bus_request_n_in,
   input  wire logic          chip_select_n_in,
   input  wire logic          ext_dma_request_one_n_in,
   input  wire logic          ext_dma_request_two_n_in,
   output mpba_req_bus_t      mp_bus_request_lines_out,
   output logic               bus_owner_indicator_out,
   output mpba_pin_t          ext_dma_grant_one_n_out,
   output mpba_pin_t          ext_dma_grant_two_n_out,
   output mpba_pin_t          host_access_ready_out
);
   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   // Pins from other chips pass two flops before any use; bus_want_in is used unsynchronised
   localparam int SW = `MPBA_ID_W + N + 5;
   logic [SW-1:0] meta_q;
   logic [SW-1:0] sync_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= '1;
         sync_q <= '1;
      end else if (ce_in) begin
         meta_q <= {processor_number_inputs_in,
                    rotating_priority_select_in,
                    mp_bus_request_lines_n_in,
                    host_bus_request_n_in, chip_select_n_in,
                    ext_dma_request_one_n_in,
                    ext_dma_request_two_n_in};
         sync_q <= meta_q;
      end
   end

   mpba_id_t       id_s;
   wire logic      rot_sel_s;
   wire logic [N-1:0] br_n_s;
   wire logic      hreq_n_s;
   wire logic      cs_n_s;
   wire logic      dreq1_n_s;
   wire logic      dreq2_n_s;
   assign {id_s, rot_sel_s, br_n_s, hreq_n_s, cs_n_s, dreq1_n_s,
           dreq2_n_s} = sync_q;

   // ********************************************************
   // Identity decode
   // ********************************************************
   wire logic      single_w;
   wire logic      id_ok_w;
   wire logic [N-1:0] own_sel_w;
   assign single_w = (id_s == `MPBA_ID_SINGLE);
   assign id_ok_w  = (id_s >= `MPBA_ID_FIRST) &&
                     (id_s <= `MPBA_ID_LAST);
   // Line k+1 belongs to identity k+1; a bad code drives nothing
   assign own_sel_w = id_ok_w ?
      N'(1) << (id_s - `MPBA_ID_FIRST) : '0;

   // ********************************************************
   // Arbitration
   // ********************************************************
   // Every processor sees the same lines and runs the same
   // evaluation, so all agree on the master each cycle
   mpba_id_t       master_q;
   mpba_id_t       master_d;
   mpba_id_t       start_w;
   mpba_id_t       win_w;
   wire logic      any_w;
   wire logic [N-1:0] req_act_w;
   wire logic      keep_w;

   assign req_act_w = ~br_n_s;
   assign start_w   = (rot_sel_s && master_q != `MPBA_NO_MASTER &&
                       master_q != `MPBA_ID_LAST)
                      ? master_q : `MPBA_IDX_ZERO;
   assign keep_w    = (master_q != `MPBA_NO_MASTER) &&
                      req_act_w[master_q - `MPBA_ID_FIRST];
   // Master parks on the bus when nobody asks
   assign master_d  = keep_w ? master_q :
                      any_w  ? win_w + `MPBA_ID_FIRST :
                               master_q;

   mpba_prio #(.N(N)) u_prio (
      .req_in   (req_act_w),
      .start_in (start_w),
      .any_out  (any_w),
      .win_out  (win_w)
   );

   wire logic      owner_d;
   assign owner_d = single_w || (id_ok_w && master_d == id_s);

   // ********************************************************
   // Output drive
   // ********************************************************
   wire logic      dgnt1_n_d;
   wire logic      dgnt2_n_d;
   wire logic      ready_d;
   assign dgnt1_n_d = !(owner_d && !dreq1_n_s);
   assign dgnt2_n_d = !(owner_d && !dreq2_n_s);
   assign ready_d   = !(!cs_n_s && !hreq_n_s);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         master_q                 <= `MPBA_NO_MASTER;
         bus_owner_indicator_out  <= 1'b0;
         mp_bus_request_lines_out <= '{o: '1, oe: '0};
         ext_dma_grant_one_n_out  <= '{o: 1'b1, oe: 1'b0};
         ext_dma_grant_two_n_out  <= '{o: 1'b1, oe: 1'b0};
         host_access_ready_out    <= '{o: 1'b1, oe: 1'b0};
      end else if (ce_in) begin
         master_q                    <= master_d;
         bus_owner_indicator_out     <= owner_d;
         mp_bus_request_lines_out.o  <= ~(own_sel_w &
                                          {N{bus_want_in}});
         mp_bus_request_lines_out.oe <= own_sel_w;
         ext_dma_grant_one_n_out     <= '{o: dgnt1_n_d,
                                          oe: owner_d};
         ext_dma_grant_two_n_out     <= '{o: dgnt2_n_d,
                                          oe: owner_d};
         // Open drain: only pulls low, released when ready
         host_access_ready_out       <= '{o: 1'b0,
                                          oe: !ready_d};
      end
   end

   // ********************************************************
   // Assertions
   // ********************************************************
   property p_ready_wait;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !cs_n_s && !hreq_n_s) |=>
         host_access_ready_out.oe && !host_access_ready_out.o;
   endproperty
   a_ready_wait: assert property (p_ready_wait)
      else $error("ready not pulled low during host access");

   property p_ready_free;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && (cs_n_s || hreq_n_s)) |=> !host_access_ready_out.oe;
   endproperty
   a_ready_free: assert property (p_ready_free)
      else $error("ready held low without host access");

   property p_grant_cause;
      @(posedge clk_in) disable iff (rst_in)
      ($past(ce_in) && ext_dma_grant_one_n_out.oe &&
       !ext_dma_grant_one_n_out.o) |-> $past(!dreq1_n_s);
   endproperty
   a_grant_cause: assert property (p_grant_cause)
      else $error("grant one without request one");

   property p_grant_cause_two;
      @(posedge clk_in) disable iff (rst_in)
      ($past(ce_in) && ext_dma_grant_two_n_out.oe &&
       !ext_dma_grant_two_n_out.o) |-> $past(!dreq2_n_s);
   endproperty
   a_grant_cause_two: assert property (p_grant_cause_two)
      else $error("grant two without request two");

   property p_grant_owner;
      @(posedge clk_in) disable iff (rst_in)
      (ext_dma_grant_one_n_out.oe || ext_dma_grant_two_n_out.oe)
         |-> bus_owner_indicator_out;
   endproperty
   a_grant_owner: assert property (p_grant_owner)
      else $error("grant driven by non-owner");

   property p_own_line;
      @(posedge clk_in) disable iff (rst_in)
      ce_in ##1 1'b1 |-> mp_bus_request_lines_out.oe ==
         $past(own_sel_w) && $onehot0(mp_bus_request_lines_out.oe);
   endproperty
   a_own_line: assert property (p_own_line)
      else $error("wrong request line driven");

   property p_single;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && single_w) |=> bus_owner_indicator_out;
   endproperty
   a_single: assert property (p_single)
      else $error("single processor not owner");

   property p_owner_match;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && id_ok_w && $stable(id_s)) |=>
         bus_owner_indicator_out == (master_q == $past(id_s));
   endproperty
   a_owner_match: assert property (p_owner_match)
      else $error("owner indicator disagrees with master");

   property p_fixed;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !rot_sel_s && !keep_w && req_act_w[0]) |=>
         master_q == `MPBA_ID_FIRST;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed priority lowest line lost");

   property p_rotate;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && rot_sel_s && !keep_w && master_q != `MPBA_NO_MASTER &&
       (req_act_w & ~(N'(1) << (master_q - `MPBA_ID_FIRST))) != '0)
         |=> master_q != $past(master_q);
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotating priority kept last master");
endmodule : mpba_arbiter
`default_nettype wire

//--- tb/mpba_peer_model.sv
`default_nettype none
`include "mpba_regs.svh"
module mpba_peer_model
   import mpba_pkg::*;
(
   input  wire mpba_req_bus_t                dut_req_in,
   input  wire logic [`MPBA_NUM_LINES-1:0]   peer_req_n_in,
   output logic      [`MPBA_NUM_LINES-1:0]   wire_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // *******************************************************
   // Wire resolution
   // *******************************************************
   // A peer bit of 1 stands for an unused or idle line held by its pull-up;
   // the device's own line is never pulled, so it follows the device.
   always_comb begin
      for (int k = 0; k < `MPBA_NUM_LINES; k++) begin
         wire_n_out[k] = dut_req_in.oe[k] ? dut_req_in.o[k]
                                          : peer_req_n_in[k];
      end
   end
endmodule : mpba_peer_model
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
`include "mpba_regs.svh"
module tb_top
   import mpba_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic          clk_in = 1'b0;
   logic          rst_in = 1'b1;
   logic          ce_in = 1'b1;
   mpba_id_t      ident = 3'h0;
   logic          rot_sel = 1'b0;
   logic [5:0]    peer_n = 6'h3f;
   logic [5:0]    wire_n;
   logic          want = 1'b0;
   logic          hreq_n = 1'b1;
   logic          cs_n = 1'b1;
   logic          dr1_n = 1'b1;
   logic          dr2_n = 1'b1;
   mpba_req_bus_t req_bus;
   logic          owner;
   mpba_pin_t     g1, g2, rdy;
   int            fail_count = 0;
   int            samples_checked = 0;
   int            cycles = 0;
   always #12.5 clk_in = ~clk_in;
   mpba_arbiter u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .processor_number_inputs_in(ident),
      .rotating_priority_select_in(rot_sel),
      .mp_bus_request_lines_n_in(wire_n), .bus_want_in(want),
      .host_bus_request_n_in(hreq_n), .chip_select_n_in(cs_n),
      .ext_dma_request_one_n_in(dr1_n), .ext_dma_request_two_n_in(dr2_n),
      .mp_bus_request_lines_out(req_bus), .bus_owner_indicator_out(owner),
      .ext_dma_grant_one_n_out(g1), .ext_dma_grant_two_n_out(g2),
      .host_access_ready_out(rdy));
   mpba_peer_model u_peer (
      .dut_req_in(req_bus), .peer_req_n_in(peer_n), .wire_n_out(wire_n));
   // *******************************************************
   // Helpers
   // *******************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(negedge clk_in);
   endtask : step
   // Identity only changes while reset is held
   task automatic do_reset(input mpba_id_t id);
      step(1);
      rst_in = 1'b1;
      ident = id;
      peer_n = 6'h3f;
      {want, hreq_n, cs_n, dr1_n, dr2_n} = 5'h0f;
      step(20);
      rst_in = 1'b0;
      step(1);
   endtask : do_reset
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // *******************************************************
   // Scenarios
   // *******************************************************
   task automatic t_single();
      do_reset(`MPBA_ID_SINGLE);
      step(4);
      check(8'(owner), 8'h01);
      check(8'(req_bus.oe), 8'h00);
      $display("test single done");
   endtask : t_single
   // Ready follows the pins three edges late, both ways
   task automatic t_ready();
      do_reset(`MPBA_ID_FIRST);
      cs_n = 1'b0;
      hreq_n = 1'b0;
      step(3);
      check(8'(rdy), 8'h01);
      hreq_n = 1'b1;
      step(2);
      check(8'(rdy), 8'h01);
      step(1);
      check(8'(rdy), 8'h00);
      cs_n = 1'b1;
      hreq_n = 1'b0;
      step(4);
      check(8'(rdy), 8'h00);
      hreq_n = 1'b1;
      $display("test ready done");
   endtask : t_ready
   // Clock enable low must hold every flop, synchronisers too
   task automatic t_freeze();
      do_reset(`MPBA_ID_FIRST);
      step(4);
      ce_in = 1'b0;
      cs_n = 1'b0;
      hreq_n = 1'b0;
      step(6);
      check(8'(rdy), 8'h00);
      ce_in = 1'b1;
      step(3);
      check(8'(rdy), 8'h01);
      cs_n = 1'b1;
      hreq_n = 1'b1;
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_lines();
      logic [7:0] m;
      for (int k = 1; k <= 6; k++) begin
         do_reset(mpba_id_t'(k));
         m = 8'h01 << (k - 1);
         want = 1'b1;
         step(5);
         check(8'(req_bus.oe), m);
         check(8'(req_bus.o), 8'h3f & ~m);
         step(4);
         check(8'(owner), 8'h01);
      end
      // An unused identity code must drive no line and never own
      do_reset(3'h7);
      want = 1'b1;
      step(9);
      check(8'(req_bus.oe), 8'h00);
      check(8'(owner), 8'h00);
      $display("test lines done");
   endtask : t_lines
   // Own line 2; line 3 masters first, then lines 2 and 4 compete
   task automatic t_arb(input logic rot, input logic [7:0] exp);
      rot_sel = rot;
      do_reset(3'h2);
      peer_n = 6'h3b;
      step(5);
      want = 1'b1;
      peer_n = 6'h33;
      step(5);
      check(8'(owner), 8'h00);
      peer_n = 6'h37;
      step(5);
      check(8'(owner), exp);
      $display("test arbitration done");
   endtask : t_arb
   task automatic t_dma();
      rot_sel = 1'b0;
      do_reset(`MPBA_ID_FIRST);
      want = 1'b1;
      step(9);
      dr1_n = 1'b0;
      step(3);
      check(8'(g1), 8'h01);
      check(8'(g2), 8'h03);
      dr2_n = 1'b0;
      step(3);
      check(8'(g2), 8'h01);
      peer_n = 6'h3d;
      want = 1'b0;
      step(6);
      check(8'(owner), 8'h00);
      check(8'(g1.oe), 8'h00);
      check(8'(g2.oe), 8'h00);
      $display("test dma done");
   endtask : t_dma
   // *******************************************************
   // Sequence and watchdog
   // *******************************************************
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      t_single();
      t_ready();
      t_lines();
      t_arb(1'b0, 8'h01);
      t_arb(1'b1, 8'h00);
      t_dma();
      t_freeze();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
